// file: rtl/nco_sel_defs.svh
// Register offsets, field positions, reset values and mode codes
`ifndef NCO_SEL_DEFS_SVH
`define NCO_SEL_DEFS_SVH
`define OFS_CHAN_CTRL     10'h314
`define OFS_PHASE_CTRL    10'h315
`define OFS_INC_B0        10'h316
`define OFS_INC_B1        10'h317
`define OFS_INC_B5        10'h31B
`define OFS_OFF_B0        10'h31D
`define OFS_OFF_B5        10'h322
`define OFS_XFER          10'h0FF
`define MODE_MSB          7
`define MODE_LSB          4
`define SEL_MSB           3
`define SEL_LSB           0
`define MODE_REGMAP       4'h0
`define MODE_PINS         4'h1
`define MODE_EDGE_A       4'h8
`define MODE_EDGE_B       4'hA
`define UPD_CONT_BIT      4
`define RESET_BYTE        8'h00
`define CHAN_ZERO         4'h0
`define CHAN_ONE          4'h1
`define WORD_BYTES        6
`define BYTE_BITS         8
`define PHASE_RD_MSB      4
`define PIN_A_BIT         0
`define PIN_B_BIT         1
`endif

// file: rtl/nco_sel_pkg.sv
// Types shared by the oscillator channel control block
package nco_sel_pkg;
  typedef logic [3:0]  chan_t;
  typedef logic [7:0]  byte_t;
  typedef logic [47:0] word48_t;
  typedef logic [9:0]  addr_t;
  typedef enum logic [1:0] {SRC_REGMAP, SRC_PINS, SRC_EDGE_A, SRC_EDGE_B} src_e;
endpackage : nco_sel_pkg

// file: rtl/pin_sync.sv
// Two-stage synchroniser with rising-edge detector
`timescale 1ns/100ps
module pin_sync (
  input  wire logic core_clk,
  input  wire logic reset,
  input  wire logic pin_in,
  output logic      level,
  output logic      rise
);
  logic meta_ff;
  logic sync_ff;
  logic prev_ff;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      prev_ff <= 1'b0;
    end else begin
      meta_ff <= pin_in;
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  assign level = sync_ff;
  assign rise  = sync_ff & ~prev_ff;
endmodule : pin_sync

// file: rtl/ddc_nco_channel_select.sv
// Oscillator channel select, phase update index and tuning/offset words
`timescale 1ns/100ps
`include "nco_sel_defs.svh"

// Summary of operation
// - Mode zero: active channel comes from the register channel select field.
// - Mode one: channel is two zeros, pin B zero, pin A zero.
// - Mode 1000: counter steps on pin A zero rising edges, drives channel.
// - Mode 1010: counter steps on pin B zero rising edges, drives channel.
// - Edge counter wraps to zero after reaching the register select value.
// - Register select field is a plain binary channel number 0 to 15.
// - Increment and offset writes go only to the indexed channel.
// - Indexed channel loads continuously or on a transfer command, per phase control bit 4.
// - Increment is a twos-complement tuning word, lowest byte in bits 7..0.
// - A 48-bit offset per channel is written bytewise and applied.
module ddc_nco_channel_select #(
  parameter int CHANNELS = 16
) (
  input  wire logic             core_clk,
  input  wire logic             reset,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  input  wire nco_sel_pkg::addr_t reg_addr,
  input  wire nco_sel_pkg::byte_t reg_wdata,
  output nco_sel_pkg::byte_t    reg_rdata_ff,
  input  wire logic             general_pin_a_zero,
  input  wire logic             general_pin_b_zero,
  output nco_sel_pkg::chan_t    active_chan_ff,
  output nco_sel_pkg::word48_t  frequency_tuning_word_ff,
  output nco_sel_pkg::word48_t  phase_offset_word_ff
);
  import nco_sel_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  byte_t   chan_ctrl_ff;
  byte_t   phase_ctrl_ff;
  word48_t inc_stage_ff;
  word48_t off_stage_ff;
  word48_t inc_mem_ff [CHANNELS];
  word48_t off_mem_ff [CHANNELS];
  chan_t   count_ff;
  logic    load_ff;
  logic    a_level;
  logic    a_rise;
  logic    b_level;
  logic    b_rise;
  src_e    src;
  chan_t   nxt_active;
  chan_t   nxt_count;
  chan_t   mode;
  chan_t   sel;
  chan_t   upd_idx;
  logic    cont_upd;
  logic    step;

  function automatic logic in_range(input addr_t a, input addr_t lo, input addr_t hi);
    return (a >= lo) && (a <= hi);
  endfunction : in_range

  function automatic logic lane_hit(input addr_t a, input addr_t base, input int lane);
    return a == addr_t'(base + addr_t'(lane));
  endfunction : lane_hit

  assign mode     = chan_ctrl_ff[`MODE_MSB:`MODE_LSB];
  assign sel      = chan_ctrl_ff[`SEL_MSB:`SEL_LSB];
  assign upd_idx  = phase_ctrl_ff[`SEL_MSB:`SEL_LSB];
  assign cont_upd = phase_ctrl_ff[`UPD_CONT_BIT];

  pin_sync u_sync_a (
    .core_clk (core_clk),
    .reset    (reset),
    .pin_in   (general_pin_a_zero),
    .level    (a_level),
    .rise     (a_rise)
  );

  pin_sync u_sync_b (
    .core_clk (core_clk),
    .reset    (reset),
    .pin_in   (general_pin_b_zero),
    .level    (b_level),
    .rise     (b_rise)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Register writes
  always_ff @(posedge core_clk) begin
    if (reset) begin
      chan_ctrl_ff  <= `RESET_BYTE;
      phase_ctrl_ff <= `RESET_BYTE;
    end else if (reg_wr) begin
      if (reg_addr == `OFS_CHAN_CTRL) begin
        chan_ctrl_ff <= reg_wdata;
      end
      if (reg_addr == `OFS_PHASE_CTRL) begin
        phase_ctrl_ff <= reg_wdata;
      end
    end
  end

  // Byte-wise staging of tuning and offset words
  always_ff @(posedge core_clk) begin
    if (reset) begin
      inc_stage_ff <= '0;
      off_stage_ff <= '0;
    end else if (reg_wr) begin
      for (int i = 0; i < `WORD_BYTES; i++) begin
        if (lane_hit(reg_addr, `OFS_INC_B0, i)) begin
          inc_stage_ff[i*`BYTE_BITS +: `BYTE_BITS] <= reg_wdata;
        end
        if (lane_hit(reg_addr, `OFS_OFF_B0, i)) begin
          off_stage_ff[i*`BYTE_BITS +: `BYTE_BITS] <= reg_wdata;
        end
      end
    end
  end

  // Transfer command pulse, or continuous loading
  always_ff @(posedge core_clk) begin
    if (reset) begin
      load_ff <= 1'b0;
    end else begin
      load_ff <= cont_upd | (reg_wr && reg_addr == `OFS_XFER);
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      for (int i = 0; i < CHANNELS; i++) begin
        inc_mem_ff[i] <= '0;
        off_mem_ff[i] <= '0;
      end
    end else if (load_ff) begin
      inc_mem_ff[upd_idx] <= inc_stage_ff;
      off_mem_ff[upd_idx] <= off_stage_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channel source and edge counter
  always_comb begin
    case (mode)
      `MODE_PINS:   src = SRC_PINS;
      `MODE_EDGE_A: src = SRC_EDGE_A;
      `MODE_EDGE_B: src = SRC_EDGE_B;
      default:      src = SRC_REGMAP;
    endcase
  end

  always_comb begin
    step = ((src == SRC_EDGE_A) && a_rise) || ((src == SRC_EDGE_B) && b_rise);
    nxt_count = count_ff;
    if (step) begin
      nxt_count = (count_ff >= sel) ? `CHAN_ZERO : count_ff + `CHAN_ONE;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      count_ff <= `CHAN_ZERO;
    end else begin
      count_ff <= nxt_count;
    end
  end

  always_comb begin
    case (src)
      SRC_PINS:   nxt_active = {2'h0, b_level, a_level};
      SRC_EDGE_A: nxt_active = nxt_count;
      SRC_EDGE_B: nxt_active = nxt_count;
      default:    nxt_active = sel;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  always_ff @(posedge core_clk) begin
    if (reset) begin
      active_chan_ff           <= `CHAN_ZERO;
      frequency_tuning_word_ff <= '0;
      phase_offset_word_ff     <= '0;
    end else begin
      active_chan_ff           <= nxt_active;
      frequency_tuning_word_ff <= inc_mem_ff[nxt_active];
      phase_offset_word_ff     <= off_mem_ff[nxt_active];
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      reg_rdata_ff <= `RESET_BYTE;
    end else if (reg_rd) begin
      reg_rdata_ff <= `RESET_BYTE;
      if (reg_addr == `OFS_CHAN_CTRL) begin
        reg_rdata_ff <= chan_ctrl_ff;
      end else if (reg_addr == `OFS_PHASE_CTRL) begin
        reg_rdata_ff <= {3'h0, phase_ctrl_ff[`PHASE_RD_MSB:`SEL_LSB]};
      end else if (in_range(reg_addr, `OFS_INC_B0, `OFS_INC_B5)) begin
        reg_rdata_ff <= inc_stage_ff[(reg_addr - `OFS_INC_B0) * `BYTE_BITS +: `BYTE_BITS];
      end else if (in_range(reg_addr, `OFS_OFF_B0, `OFS_OFF_B5)) begin
        reg_rdata_ff <= off_stage_ff[(reg_addr - `OFS_OFF_B0) * `BYTE_BITS +: `BYTE_BITS];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence regmap_mode_s;
    src == SRC_REGMAP;
  endsequence

  // Load into the channel that is also the active one
  sequence active_load_s;
    load_ff && src == SRC_REGMAP && upd_idx == sel;
  endsequence

  // Same channel still selected one cycle later
  sequence still_active_s;
    src == SRC_REGMAP && sel == $past(upd_idx);
  endsequence

  // Pin rises in pin mode and stays up while it crosses the synchroniser
  sequence pin_a_rise_s;
    src == SRC_PINS && $rose(general_pin_a_zero);
  endsequence

  sequence pin_a_held_s;
    (src == SRC_PINS && general_pin_a_zero) [*2];
  endsequence

  sequence pin_b_rise_s;
    src == SRC_PINS && $rose(general_pin_b_zero);
  endsequence

  sequence pin_b_held_s;
    (src == SRC_PINS && general_pin_b_zero) [*2];
  endsequence

  regmap_select_a: assert property (@(posedge core_clk) disable iff (reset)
    regmap_mode_s |=> active_chan_ff == $past(sel)) else $error("regmap select wrong");

  pin_select_a: assert property (@(posedge core_clk) disable iff (reset)
    src == SRC_PINS |=> active_chan_ff == {2'h0, $past(b_level), $past(a_level)})
    else $error("pin select wrong");

  pin_a_latency_a: assert property (@(posedge core_clk) disable iff (reset)
    pin_a_rise_s ##1 pin_a_held_s |=> active_chan_ff[`PIN_A_BIT]) else $error("pin A late");
  pin_b_latency_a: assert property (@(posedge core_clk) disable iff (reset)
    pin_b_rise_s ##1 pin_b_held_s |=> active_chan_ff[`PIN_B_BIT]) else $error("pin B late");

  edge_a_step_a: assert property (@(posedge core_clk) disable iff (reset)
    (src == SRC_EDGE_A && a_rise && count_ff < sel) |=> count_ff == $past(count_ff) + `CHAN_ONE)
    else $error("edge A count wrong");
  edge_b_step_a: assert property (@(posedge core_clk) disable iff (reset)
    (src == SRC_EDGE_B && b_rise && count_ff < sel) |=> count_ff == $past(count_ff) + `CHAN_ONE)
    else $error("edge B count wrong");

  count_hold_a: assert property (@(posedge core_clk) disable iff (reset)
    !((src == SRC_EDGE_A && a_rise) || (src == SRC_EDGE_B && b_rise)) |=> $stable(count_ff))
    else $error("counter moved without edge");
  edge_chan_a: assert property (@(posedge core_clk) disable iff (reset)
    (src == SRC_EDGE_A || src == SRC_EDGE_B) |=> active_chan_ff == count_ff)
    else $error("edge mode channel wrong");

  count_wrap_a: assert property (@(posedge core_clk) disable iff (reset)
    (step && count_ff >= sel) |=> count_ff == `CHAN_ZERO) else $error("counter did not wrap");

  reserved_mode_a: assert property (@(posedge core_clk) disable iff (reset)
    (!(mode inside {`MODE_REGMAP, `MODE_PINS, `MODE_EDGE_A, `MODE_EDGE_B})) |=>
      active_chan_ff == $past(sel)) else $error("reserved mode not regmap");
  chan_readback_a: assert property (@(posedge core_clk) disable iff (reset)
    (reg_rd && reg_addr == `OFS_CHAN_CTRL) |=> reg_rdata_ff == $past(chan_ctrl_ff))
    else $error("channel control readback wrong");

  inc_byte_write_a: assert property (@(posedge core_clk) disable iff (reset)
    (reg_wr && reg_addr == `OFS_INC_B0) |=> inc_stage_ff[`BYTE_BITS-1:0] == $past(reg_wdata))
    else $error("increment byte zero not staged");
  off_byte_write_a: assert property (@(posedge core_clk) disable iff (reset)
    (reg_wr && reg_addr == `OFS_OFF_B0) |=> off_stage_ff[`BYTE_BITS-1:0] == $past(reg_wdata))
    else $error("offset byte zero not staged");

  indexed_load_a: assert property (@(posedge core_clk) disable iff (reset)
    load_ff |=> inc_mem_ff[$past(upd_idx)] == $past(inc_stage_ff)) else $error("load missed");
  offset_load_a: assert property (@(posedge core_clk) disable iff (reset)
    load_ff |=> off_mem_ff[$past(upd_idx)] == $past(off_stage_ff)) else $error("offset missed");

  // Channels other than the indexed one keep their words across a load
  for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_keep
    other_chan_keep_a: assert property (@(posedge core_clk) disable iff (reset)
      (!load_ff || upd_idx != chan_t'(ch)) |=>
        inc_mem_ff[ch] == $past(inc_mem_ff[ch]) && off_mem_ff[ch] == $past(off_mem_ff[ch]))
      else $error("unindexed channel changed");
  end

  xfer_load_a: assert property (@(posedge core_clk) disable iff (reset)
    (reg_wr && reg_addr == `OFS_XFER) |=> load_ff) else $error("transfer not taken");
  no_spurious_load_a: assert property (@(posedge core_clk) disable iff (reset)
    (!cont_upd && !(reg_wr && reg_addr == `OFS_XFER)) |=> !load_ff)
    else $error("load without transfer");

  word_follow_a: assert property (@(posedge core_clk) disable iff (reset)
    active_load_s ##1 still_active_s |=>
      frequency_tuning_word_ff == $past(inc_stage_ff, 2) &&
      phase_offset_word_ff == $past(off_stage_ff, 2))
    else $error("active words not delivered");
endmodule : ddc_nco_channel_select

// file: sim/pin_driver.sv
// Model of the external logic that drives the two select pins
`timescale 1ns/100ps
module pin_driver (
  input  wire logic core_clk,
  output logic      pin_a,
  output logic      pin_b
);
  initial begin
    pin_a = 1'b0;
    pin_b = 1'b0;
  end
  task automatic set_pins(input logic a, input logic b);
    @(negedge core_clk);
    pin_a = a;
    pin_b = b;
  endtask : set_pins
  // One clean rising edge per step, held past the synchroniser
  task automatic step(input logic on_b);
    set_pins(~on_b, on_b);
    repeat (3) @(negedge core_clk);
    pin_a = 1'b0;
    pin_b = 1'b0;
    repeat (3) @(negedge core_clk);
  endtask : step
endmodule : pin_driver

// file: sim/ddc_nco_channel_select_tb.sv
// Self-checking testbench of the oscillator channel select block
`timescale 1ns/100ps
module ddc_nco_channel_select_tb;
  import nco_sel_pkg::*;
  logic    core_clk  = 1'b0;
  logic    reset     = 1'b1;
  logic    reg_wr    = 1'b0;
  logic    reg_rd    = 1'b0;
  addr_t   reg_addr  = '0;
  byte_t   reg_wdata = '0;
  byte_t   reg_rdata_ff;
  logic    pin_a;
  logic    pin_b;
  chan_t   active_chan_ff;
  word48_t frequency_tuning_word;
  word48_t phase_offset_word;
  byte_t   v;
  chan_t   e;
  int      n_mismatch = 0;
  int      n_tests    = 0;
  always #10 core_clk = ~core_clk;
  pin_driver i_pins (.core_clk(core_clk), .pin_a(pin_a), .pin_b(pin_b));
  ddc_nco_channel_select i_dut (
    .core_clk(core_clk), .reset(reset), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff),
    .general_pin_a_zero(pin_a), .general_pin_b_zero(pin_b),
    .active_chan_ff(active_chan_ff), .frequency_tuning_word_ff(frequency_tuning_word),
    .phase_offset_word_ff(phase_offset_word)
  );
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [47:0] seen, input logic [47:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic do_reset();
    @(negedge core_clk);
    reset = 1'b1;
    repeat (16) @(negedge core_clk);
    reset = 1'b0;
  endtask : do_reset
  task automatic wr(input addr_t a, input byte_t d);
    @(negedge core_clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge core_clk);
    reg_wr = 1'b0;
    repeat (3) @(negedge core_clk);
  endtask : wr
  task automatic rd(input addr_t a, output byte_t d);
    @(negedge core_clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge core_clk);
    reg_rd = 1'b0;
    @(negedge core_clk);
    d = reg_rdata_ff;
  endtask : rd
  ////////////////////////////////////////////////////////////////////////////
  task automatic test_reset();
    rd(10'h314, v);
    chk("chan_ctrl", v, 48'h0);
    rd(10'h315, v);
    chk("phase_ctrl", v, 48'h0);
    rd(10'h316, v);
    chk("inc_byte0", v, 48'h0);
    chk("active_chan", active_chan_ff, 48'h0);
    $display("test reset done");
  endtask : test_reset
  task automatic test_regmap();
    for (int c = 15; c >= 0; c -= 5) begin
      e = chan_t'(c);
      wr(10'h314, {4'h0, e});
      chk("active_chan", active_chan_ff, e);
    end
    for (int m = 2; m < 16; m += 7) begin
      wr(10'h314, {4'(m), 4'h6});
      chk("reserved_mode", active_chan_ff, 48'h6);
    end
    $display("test regmap done");
  endtask : test_regmap
  task automatic test_pins();
    wr(10'h314, 8'h1F);
    for (int p = 0; p < 4; p++) begin
      i_pins.set_pins(p[0], p[1]);
      repeat (5) @(negedge core_clk);
      chk("pin_chan", active_chan_ff, 48'(p));
    end
    i_pins.set_pins(1'b0, 1'b0);
    $display("test pins done");
  endtask : test_pins
  task automatic test_edges();
    do_reset();
    wr(10'h314, 8'h82);
    e = 4'h0;
    for (int i = 0; i < 4; i++) begin
      i_pins.step(1'b0);
      e = (e == 4'h2) ? 4'h0 : e + 4'h1;
      chk("edge_a_chan", active_chan_ff, e);
    end
    i_pins.step(1'b1);
    chk("edge_a_ignores_b", active_chan_ff, e);
    wr(10'h314, 8'hA3);
    for (int i = 0; i < 3; i++) begin
      i_pins.step(1'b1);
      e = (e == 4'h3) ? 4'h0 : e + 4'h1;
      chk("edge_b_chan", active_chan_ff, e);
    end
    $display("test edges done");
  endtask : test_edges
  task automatic test_phase();
    wr(10'h314, 8'h03);
    wr(10'h315, 8'h03);
    wr(10'h316, 8'hA5);
    chk("ftw_held", frequency_tuning_word, 48'h0);
    wr(10'h0FF, 8'h00);
    chk("ftw_xfer", frequency_tuning_word, 48'hA5);
    rd(10'h316, v);
    chk("inc_byte0", v, 48'hA5);
    wr(10'h315, 8'hF3);
    rd(10'h315, v);
    chk("phase_ctrl", v, 48'h13);
    wr(10'h31B, 8'h80);
    chk("ftw_cont", frequency_tuning_word, 48'h8000_0000_00A5);
    wr(10'h31D, 8'h11);
    chk("pow_cont", phase_offset_word, 48'h11);
    wr(10'h314, 8'h02);
    chk("ftw_other", frequency_tuning_word, 48'h0);
    chk("pow_other", phase_offset_word, 48'h0);
    rd(10'h3FF, v);
    chk("unmapped", v, 48'h0);
    $display("test phase done");
  endtask : test_phase
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : print_verdict
  initial begin
    do_reset();
    test_reset();
    test_regmap();
    test_pins();
    test_edges();
    test_phase();
    print_verdict();
  end
endmodule : ddc_nco_channel_select_tb
